// ### src/frt_pkg.sv
// Shared constants and types for the free-running timer counter block.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz CPU clock.
package frt_pkg;

	// Counter geometry
	localparam int          CNT_W        = 16;
	localparam logic [15:0] CNT_PRESET   = 16'hFFFC;
	localparam logic [15:0] CNT_MAX      = 16'hFFFF;

	// Register byte addresses (word aligned)
	localparam logic [7:0]  ADDR_CNT_HI  = 8'h00;
	localparam logic [7:0]  ADDR_CNT_LO  = 8'h04;
	localparam logic [7:0]  ADDR_ALT_HI  = 8'h08;
	localparam logic [7:0]  ADDR_ALT_LO  = 8'h0C;
	localparam logic [7:0]  ADDR_STATUS  = 8'h10;
	localparam logic [7:0]  ADDR_CTRL1   = 8'h14;
	localparam logic [7:0]  ADDR_CTRL2   = 8'h18;

	// Field positions
	localparam int          OVF_BIT      = 7;
	localparam int          IRQEN_BIT    = 7;
	localparam int          EDGE_BIT     = 2;
	localparam int          CLKSEL_LSB   = 0;

	// Prescaler terminal patterns
	localparam logic [2:0]  PRE_DIV2     = 3'h1;
	localparam logic [2:0]  PRE_DIV4     = 3'h3;
	localparam logic [2:0]  PRE_DIV8     = 3'h7;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// Counter tick source
	typedef enum logic [1:0] {
		CLK_DIV2 = 2'h0,
		CLK_DIV4 = 2'h1,
		CLK_DIV8 = 2'h2,
		CLK_EXT  = 2'h3
	} clk_sel_e;

	// Software control fields
	typedef struct packed {
		logic     irq_en;   // overflow_irq_enable
		logic     ext_edge; // ext_edge_select: 1 rising, 0 falling
		clk_sel_e clk_sel;  // clock_select_bits
	} timer_ctrl_s;

	// Device-level conditions seen by the timer
	typedef struct packed {
		logic halt;         // Halt low-power mode
		logic wait_mode;    // Wait low-power mode
		logic irq_mask;     // CPU global interrupt mask
		logic ext_bonded;   // External clock pin present
	} dev_state_s;

endpackage

// ### src/pin_edge_sync.sv
// Two-flop synchroniser with a selectable active-edge detector.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Pin and edge choice
	input  wire logic pin_in,
	input  wire logic rising_sel,
	// Detected active edge, one cycle
	output logic      edge_pulse
);

	logic meta_reg;   // First stage, read only by sync_reg
	logic sync_reg;   // Second stage
	logic prev_reg;   // Delayed copy for edge detection

	// Synchroniser chain; idles high like an undriven pin
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Rising or falling transition, as selected
	assign edge_pulse = rising_sel ? (sync_reg & ~prev_reg)
	                               : (~sync_reg & prev_reg);

endmodule

`default_nettype wire

// ### src/free_running_timer_counter.sv
// Free-running 16-bit timer counter with AXI4-Lite register access.
// Assumes clock at 25 MHz, rst_n asynchronous active low, and an external
// clock pin that is asynchronous to clock.
//
// Function
// - 16-bit free-running counter, byte-wide register pairs
// - Tick from clock/2, /4, /8 or pin
// - Both select bits one picks external clock
// - Edge select bit picks rising or falling
// - Counter updates on the CPU clock only
// - Low byte write presets counter to FFFC
// - Counter resets to FFFC
// - Alternate view same count, keeps overflow flag
// - High byte read first latches low byte
// - Latched low byte frozen until low read
// - Lone low read returns live low byte
// - Wrap from FFFF to 0000 sets flag
// - Interrupt needs enable and clear CPU mask
// - Flag clears: status read, then low access
// - Counter keeps running in Wait mode
// - Halt freezes counter, resumes from frozen count
// - Unbonded pin is seen as one
// - Instances share nothing, run in lockstep
// - Internal reset active high means reset
`timescale 1ns/100ps
`default_nettype none

module free_running_timer_counter (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// AXI4-Lite write address
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Device conditions
	input  wire frt_pkg::dev_state_s dev_state,
	// External clock pin
	input  wire logic              ext_clock_pin,
	// Overflow interrupt request
	output logic                   overflow_irq
);

	import frt_pkg::*;

	// Internal active-high reset view
	logic                 device_reset;

	// Counter and prescaler state
	logic [CNT_W-1:0]     count_reg;                // Free-running count
	logic [2:0]           presc_reg;                // CPU clock divider
	logic                 tick;                     // One count step
	logic                 ext_edge;                 // Synchronised pin edge
	logic                 pin_seen;                 // Pin after bonding

	// Software control
	timer_ctrl_s          ctrl_reg;

	// Read sequence and flag state
	logic [7:0]           low_buf_reg;              // Latched low byte
	logic                 latch_active_reg;         // Sequence in progress
	logic                 overflow_flag;            // Sticky wrap flag
	logic                 clear_armed_reg;          // Status read seen

	// AXI write channel holding
	logic                 aw_full_reg;
	logic [7:0]           aw_addr_reg;
	logic                 w_full_reg;
	logic [31:0]          w_data_reg;
	logic [3:0]           w_strb_reg;
	logic                 bvalid_reg;
	logic [1:0]           bresp_reg;

	// AXI read channel
	logic                 rvalid_reg;
	logic [31:0]          rdata_reg;
	logic [1:0]           rresp_reg;

	// Access strobes
	logic                 wr_go;                    // Write performed now
	logic                 rd_go;                    // Read taken now
	logic                 wr_lo_main;
	logic                 wr_lo_any;
	logic                 rd_hi_any;
	logic                 rd_lo_any;
	logic                 rd_lo_main;
	logic                 rd_status;
	logic                 wrap_event;
	logic [31:0]          rd_value;
	logic                 rd_hit;
	logic                 wr_hit;

	assign device_reset = ~rst_n;

	// Unbonded pin reads as logic one
	assign pin_seen = dev_state.ext_bonded ? ext_clock_pin : 1'b1;

	// Pin synchroniser and active-edge detector
	pin_edge_sync u_pin_sync (
		.clock      (clock),
		.rst_n      (rst_n),
		.pin_in     (pin_seen),
		.rising_sel (ctrl_reg.ext_edge),
		.edge_pulse (ext_edge)
	);

	// Tick selection from prescaler or pin
	always_comb begin
		case (ctrl_reg.clk_sel)
			CLK_DIV2: tick = (presc_reg[0] == PRE_DIV2[0]);
			CLK_DIV4: tick = (presc_reg[1:0] == PRE_DIV4[1:0]);
			CLK_DIV8: tick = (presc_reg == PRE_DIV8);
			CLK_EXT:  tick = ext_edge;
			default:  tick = 1'b0;
		endcase
		// Halt stops every tick; Wait has no effect
		if (dev_state.halt) begin
			tick = 1'b0;
		end
	end

	// Prescaler counts from reset and holds in Halt, so twin instances stay aligned
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			presc_reg <= 3'h0;
		end else if (!dev_state.halt) begin
			presc_reg <= presc_reg + 3'h1;
		end
	end

	// Wrap detection on the step out of the maximum count
	assign wrap_event = tick && (count_reg == CNT_MAX);

	// The counter; all updates land on the single CPU clock edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= CNT_PRESET;
		end else if (wr_lo_any) begin
			count_reg <= CNT_PRESET;
		end else if (tick) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// Register decode for the access in progress
	assign wr_go      = aw_full_reg && w_full_reg && !bvalid_reg;
	assign rd_go      = s_axi_arvalid && s_axi_arready;
	assign wr_lo_main = wr_go && w_strb_reg[0]
	                    && (aw_addr_reg == ADDR_CNT_LO);
	assign wr_lo_any  = wr_go && w_strb_reg[0]
	                    && ((aw_addr_reg == ADDR_CNT_LO)
	                    ||  (aw_addr_reg == ADDR_ALT_LO));
	assign rd_hi_any  = rd_go && ((s_axi_araddr == ADDR_CNT_HI)
	                    ||  (s_axi_araddr == ADDR_ALT_HI));
	assign rd_lo_main = rd_go && (s_axi_araddr == ADDR_CNT_LO);
	assign rd_lo_any  = rd_lo_main
	                    || (rd_go && (s_axi_araddr == ADDR_ALT_LO));
	assign rd_status  = rd_go && (s_axi_araddr == ADDR_STATUS);

	// Low-byte buffer; reloaded only by the first high read
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			low_buf_reg      <= 8'h00;
			latch_active_reg <= 1'b0;
		end else if (rd_hi_any && !latch_active_reg) begin
			low_buf_reg      <= count_reg[7:0];
			latch_active_reg <= 1'b1;
		end else if (rd_lo_any) begin
			latch_active_reg <= 1'b0;
		end
	end

	// Overflow flag; a wrap in the clearing cycle wins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overflow_flag <= 1'b0;
		end else if (wrap_event) begin
			overflow_flag <= 1'b1;
		end else if (clear_armed_reg && (rd_lo_main || wr_lo_main)) begin
			overflow_flag <= 1'b0;
		end
	end

	// First clearing step: status read while the flag is set
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clear_armed_reg <= 1'b0;
		end else if (rd_status && overflow_flag) begin
			clear_armed_reg <= 1'b1;
		end else if (rd_lo_main || wr_lo_main) begin
			clear_armed_reg <= 1'b0;
		end
	end

	// Interrupt request held pending behind enable and CPU mask
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overflow_irq <= 1'b0;
		end else begin
			overflow_irq <= overflow_flag && ctrl_reg.irq_en
			                && !dev_state.irq_mask;
		end
	end

	// Control register writes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= '{irq_en: 1'b0, ext_edge: 1'b0, clk_sel: CLK_DIV2};
		end else if (wr_go && w_strb_reg[0]) begin
			if (aw_addr_reg == ADDR_CTRL1) begin
				ctrl_reg.irq_en   <= w_data_reg[IRQEN_BIT];
			end else if (aw_addr_reg == ADDR_CTRL2) begin
				ctrl_reg.ext_edge <= w_data_reg[EDGE_BIT];
				ctrl_reg.clk_sel  <= clk_sel_e'(
					w_data_reg[CLKSEL_LSB +: 2]);
			end
		end
	end

	// Read value mux; both views return the same count
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_hit   = 1'b1;
		case (s_axi_araddr)
			ADDR_CNT_HI, ADDR_ALT_HI: begin
				rd_value[7:0] = count_reg[15:8];
			end
			ADDR_CNT_LO, ADDR_ALT_LO: begin
				rd_value[7:0] = latch_active_reg ? low_buf_reg
				                : count_reg[7:0];
			end
			ADDR_STATUS: begin
				rd_value[OVF_BIT] = overflow_flag;
			end
			ADDR_CTRL1: begin
				rd_value[IRQEN_BIT] = ctrl_reg.irq_en;
			end
			ADDR_CTRL2: begin
				rd_value[EDGE_BIT] = ctrl_reg.ext_edge;
				rd_value[CLKSEL_LSB +: 2] = ctrl_reg.clk_sel;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Write address decode for the response code
	always_comb begin
		case (aw_addr_reg)
			ADDR_CNT_HI, ADDR_CNT_LO, ADDR_ALT_HI, ADDR_ALT_LO,
			ADDR_STATUS, ADDR_CTRL1, ADDR_CTRL2: begin
				wr_hit = 1'b1;
			end
			default: begin
				wr_hit = 1'b0;
			end
		endcase
	end

	// Write address and data are taken independently
	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready  = !w_full_reg && !bvalid_reg;

	// Write address holding
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_full_reg <= 1'b0;
		end
	end

	// Write data holding
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_go) begin
			w_full_reg <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// One read at a time: address taken only with no data pending
	assign s_axi_arready = !rvalid_reg;

	// Read data register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= RESP_OKAY;
		end else if (rd_go) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_value;
			rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// Wait mode is accepted but deliberately changes nothing
	logic unused_wait;
	assign unused_wait = dev_state.wait_mode ^ device_reset;

endmodule

`default_nettype wire

// ### testbench/frt_properties.sv
// Concurrent checks on the timer bus handshakes and overflow interrupt.
// Assumes binding to the ports of free_running_timer_counter.
`timescale 1ns/100ps
`default_nettype none

module frt_properties (
	// Clock and reset
	input wire logic                clock,
	input wire logic                rst_n,
	// Write side
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wready,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	// Read side
	input wire logic [7:0]          s_axi_araddr,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic [1:0]          s_axi_rresp,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	// Device state and interrupt
	input wire frt_pkg::dev_state_s dev_state,
	input wire logic                overflow_irq
);
	import frt_pkg::*;

	// One clock domain for every check
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer stuck");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr > 8'h18 |=> s_axi_rresp == RESP_SLVERR) else $error("no error");
	a_mapped_read: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == ADDR_STATUS |=> s_axi_rresp == RESP_OKAY) else $error("bad resp");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_irq_masked: assert property (dev_state.irq_mask |=> !overflow_irq)
		else $error("interrupt while masked");

	// Main scenarios reached
	c_irq: cover property (overflow_irq);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

`default_nettype wire

// ### testbench/ext_pin_model.sv
// External clock pin source standing outside the timer.
// Assumes the bench calls toggle from its own sequence.
`timescale 1ns/100ps
`default_nettype none

module ext_pin_model (
	// Clock
	input wire logic clock,
	// Pin driven into the block
	output var logic ext_clock_pin
);
	// Pin rests low and holds between bursts
	initial ext_clock_pin = 1'b0;

	// Toggle the pin n times, five clocks apart
	task automatic toggle(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (5) @(posedge clock);
			ext_clock_pin <= ~ext_clock_pin;
		end
		repeat (5) @(posedge clock);
	endtask
endmodule

`default_nettype wire

// ### testbench/free_running_timer_counter_test.sv
// Self-checking bench for the free-running timer counter.
// Assumes the design package and the pin model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module free_running_timer_counter_test;
	import frt_pkg::*;

	// Bus, device and bench signals
	logic        clock, rst_n;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, ext_clock_pin, overflow_irq;
	dev_state_s  dev_state;
	int          miscompares, total_checks;

	free_running_timer_counter i_free_running_timer_counter (
		.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .dev_state, .ext_clock_pin,
		.overflow_irq
	);
	ext_pin_model i_ext_pin_model (.clock, .ext_clock_pin);

	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compare and count
	task automatic chk(input string nm, input logic [15:0] e, g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// A wait that ran out
	task automatic hang();
		chk("bus answer", 16'h0001, 16'h0000);
		end_of_test();
	endtask

	// Register write; bready rises only once the answer stands, so the
	// design must hold bvalid for a cycle with bready low
	task automatic wr(input logic [7:0] a, d, output logic [1:0] rsp);
		logic aw, w, b;
		b = 1'b0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wvalid <= 1'b1;
		for (int n = 0; n < 40 && !b; n++) begin
			@(negedge clock);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			@(posedge clock);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		if (!b) begin
			hang();
		end else begin
			s_axi_bready <= 1'b1;
			@(negedge clock);
			rsp = s_axi_bresp;
			@(posedge clock);
			s_axi_bready <= 1'b0;
		end
	endtask

	// Register read; rready rises only once the data stands
	task automatic rd(input logic [7:0] a, output logic [7:0] v,
		output logic [1:0] rsp);
		logic ar, r;
		r = 1'b0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (int n = 0; n < 40 && !r; n++) begin
			@(negedge clock);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			@(posedge clock);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		if (!r) begin
			hang();
		end else begin
			s_axi_rready <= 1'b1;
			@(negedge clock);
			v = s_axi_rdata[7:0];
			rsp = s_axi_rresp;
			@(posedge clock);
			s_axi_rready <= 1'b0;
		end
	endtask

	// Read and compare one register
	task automatic rdchk(input string nm, input logic [7:0] a, e);
		logic [7:0] v;
		logic [1:0] r;
		rd(a, v, r);
		chk(nm, e, v);
	endtask

	// Full count through the alternate view, high byte first
	task automatic cnt(output logic [15:0] c);
		logic [1:0] r;
		rd(ADDR_ALT_HI, c[15:8], r);
		rd(ADDR_ALT_LO, c[7:0], r);
	endtask

	// Leave halt for exactly m clocks
	task automatic run(input int m);
		dev_state.halt <= 1'b0;
		repeat (m) @(posedge clock);
		dev_state.halt <= 1'b1;
	endtask

	// Pin bursts with the counter running
	task automatic burst(input int k);
		dev_state.halt <= 1'b0;
		i_ext_pin_model.toggle(k);
		dev_state.halt <= 1'b1;
	endtask

	initial begin : main
		logic [15:0] c0, c1;
		logic [7:0] v;
		logic [1:0] rsp;
		rst_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		dev_state = '{halt: 1'b1, wait_mode: 1'b0, irq_mask: 1'b1,
			ext_bonded: 1'b1};
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		rdchk("count high", ADDR_CNT_HI, 8'hFF);
		rdchk("count low", ADDR_CNT_LO, 8'hFC);
		rdchk("status", ADDR_STATUS, 8'h00);
		rdchk("control two", ADDR_CTRL2, 8'h00);
		$display("test reset done");
		// Six ticks per run at each divider, wait mode on
		dev_state.wait_mode <= 1'b1;
		for (int s = 0; s < 3; s++) begin
			wr(ADDR_CTRL2, 8'(s), rsp);
			cnt(c0);
			run(12 << s);
			cnt(c1);
			chk("ticks", 16'(c0 + 16'd6), c1);
		end
		rdchk("flag set", ADDR_STATUS, 8'h80);
		rd(ADDR_ALT_LO, v, rsp);
		rdchk("flag kept", ADDR_STATUS, 8'h80);
		rd(ADDR_CNT_LO, v, rsp);
		rdchk("flag clear", ADDR_STATUS, 8'h00);
		$display("test prescaler done");
		wr(ADDR_CNT_LO, 8'h00, rsp);
		cnt(c0);
		chk("preset", 16'hFFFC, c0);
		wr(ADDR_CTRL1, 8'h80, rsp);
		rdchk("control one", ADDR_CTRL1, 8'h80);
		run(32);
		repeat (3) @(posedge clock);
		chk("masked irq", 16'h0000, 16'(overflow_irq));
		dev_state.irq_mask <= 1'b0;
		repeat (3) @(posedge clock);
		chk("irq", 16'h0001, 16'(overflow_irq));
		wr(ADDR_CNT_LO, 8'h00, rsp);
		rdchk("unarmed", ADDR_STATUS, 8'h80);
		wr(ADDR_ALT_LO, 8'h00, rsp);
		rdchk("alt write", ADDR_STATUS, 8'h80);
		wr(ADDR_CNT_LO, 8'h00, rsp);
		repeat (3) @(posedge clock);
		chk("irq clear", 16'h0000, 16'(overflow_irq));
		rdchk("cleared", ADDR_STATUS, 8'h00);
		$display("test overflow done");
		rdchk("first high", ADDR_CNT_HI, 8'hFF);
		run(40);
		rdchk("high again", ADDR_CNT_HI, 8'h00);
		rdchk("buffered low", ADDR_CNT_LO, 8'hFC);
		rdchk("live low", ADDR_CNT_LO, 8'h01);
		rd(8'h20, v, rsp);
		chk("read resp", RESP_SLVERR, rsp);
		wr(8'h1C, 8'h00, rsp);
		chk("write resp", RESP_SLVERR, rsp);
		// A write with the low byte lane off must leave the count alone
		s_axi_wstrb <= 4'h0;
		wr(ADDR_CNT_LO, 8'h00, rsp);
		s_axi_wstrb <= 4'hF;
		chk("masked resp", RESP_OKAY, rsp);
		rdchk("masked write", ADDR_CNT_LO, 8'h01);
		$display("test read sequence done");
		wr(ADDR_CTRL2, 8'h07, rsp);
		cnt(c0);
		burst(5);
		cnt(c1);
		chk("rising edges", 16'(c0 + 16'd3), c1);
		wr(ADDR_CTRL2, 8'h03, rsp);
		burst(4);
		cnt(c0);
		chk("falling edges", 16'(c1 + 16'd2), c0);
		dev_state.ext_bonded <= 1'b0;
		burst(4);
		cnt(c1);
		chk("unbonded", c0, c1);
		$display("test external clock done");
		end_of_test();
	end
endmodule

bind free_running_timer_counter frt_properties i_frt_properties (
	.clock, .rst_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.dev_state, .overflow_irq
);

`default_nettype wire
